// ==== rtl/pia_pkg.sv ====
// Purpose: Constants for the prioritised interrupt acceptance block
// Assumes: 100 MHz core_clk, one entry state per clock cycle
// Notes: Byte offsets on a 32-bit Avalon-MM register bus
package pia_pkg;
  localparam int NUM_HW = 36;
  localparam int NUM_CPU = 9;
  localparam int HW_BASE_IDX = 8;
  localparam int NUM_NMI = 2;
  localparam int NUM_DMA = 4;
  localparam int NUM_PRIO_REGS = 5;
  localparam logic [2:0] LVL_TOP = 3'h7;
  localparam logic [2:0] LVL_MIN_EI = 3'h1;
  localparam logic [2:0] LVL_MASK_RESET = 3'h7;
  localparam logic [7:0] VEC_ILLEGAL = 8'h08;
  localparam logic [23:0] VEC_TABLE_BASE = 24'hffff00;
  localparam logic [7:0] ENTRY_88 = 8'h23;
  localparam logic [7:0] ENTRY_816 = 8'h1f;
  localparam logic [7:0] ENTRY_168 = 8'h1d;
  localparam logic [7:0] ENTRY_1616 = 8'h19;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DMAVEC = 8'h04;
  localparam logic [7:0] REG_PRIO0 = 8'h08;
  localparam logic [7:0] REG_PEND_LO = 8'h20;
  localparam logic [7:0] REG_PEND_HI = 8'h24;
  // CTRL fields
  localparam int CTRL_STK16 = 0;
  localparam int CTRL_VEC16 = 1;
  localparam int CTRL_MASK_LSB = 8;
  localparam int CTRL_NEST_LSB = 16;
  localparam int PRIO_PER_REG = 8;
  localparam int PRIO_FIELD_W = 4;
  localparam logic [31:0] DMAVEC_RESET = 32'h00000000;
  typedef enum logic [2:0] {
    PIA_IDLE = 3'b001,
    PIA_ENTRY = 3'b010,
    PIA_DONE = 3'b100
  } pia_state_e;
endpackage : pia_pkg

// ==== rtl/pia_intc.sv ====
// Purpose: Interrupt prioritisation, acceptance and entry sequencing
// Assumes: Sequencer signals on core_clk; hardware requests asynchronous
// Notes: Mask, nesting count and entry timing are owned here
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module pia_intc
  import pia_pkg::*;
#(
  parameter int NEST_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [pia_pkg::NUM_HW-1:0] hwReq,
  input wire logic instrBoundary,
  input wire logic softwareTrapInstr,
  input wire logic [2:0] softwareTrapNum,
  input wire logic illegalTrap,
  input wire logic maskLoadInstr,
  input wire logic [2:0] maskLoadOperand,
  input wire logic maskAllInstr,
  input wire logic handlerReturnInstr,
  input wire logic [2:0] restoredMaskLevel,
  input wire logic [pia_pkg::NUM_DMA-1:0] dmaCountZero,
  output logic [2:0] presentedLevel,
  output logic [2:0] interruptMaskLevel,
  output logic [NEST_W-1:0] nestingCount,
  output logic entryBusy,
  output logic pushReq,
  output logic [23:0] vectorFetchAddr,
  output logic handlerGo,
  output logic dmaGo,
  output logic [1:0] dmaChannel
);
  import pia_pkg::*;
  if (NEST_W < 2 || NEST_W > 16) begin : g_nestCheck
    $error("NEST_W out of range");
  end
  function automatic logic [2:0] maskAfter(input logic [2:0] lvl);
    maskAfter = (lvl == LVL_TOP) ? LVL_TOP : 3'(lvl + 3'h1);
  endfunction : maskAfter
  function automatic logic [7:0] vecOf(input logic [5:0] idx);
    vecOf = {idx, 2'b00};
  endfunction : vecOf
  //////////////////////////////////////////////////////////////////////
  // Request synchronisers and pending latches
  logic [NUM_HW-1:0] syncA_q, syncB_q, syncC_q, pend_q;
  logic [NUM_HW-1:0] pendClr;
  wire [NUM_HW-1:0] reqEdge = syncB_q & ~syncC_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      syncA_q <= '0;
      syncB_q <= '0;
      syncC_q <= '0;
      pend_q <= '0;
    end else if (ce) begin
      syncA_q <= hwReq;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      pend_q <= (pend_q & ~pendClr) | reqEdge; // set wins
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] dmaVec_q;
  logic [NUM_PRIO_REGS*32-1:0] prio_q;
  logic stk16_q, vec16_q;
  logic waitReq_q;
  logic [31:0] rdata_q;
  wire [7:0] busAddr = {avs_address, 2'b00};
  wire busStart = (avs_read | avs_write) & waitReq_q;
  wire wrCtrl = busStart & avs_write & (busAddr == REG_CTRL);
  wire wrDma = busStart & avs_write & (busAddr == REG_DMAVEC);
  wire prioHit = (busAddr >= REG_PRIO0) && (busAddr < REG_PRIO0 + 8'(4 * NUM_PRIO_REGS));
  wire [2:0] prioSel = 3'((busAddr - REG_PRIO0) >> 2);
  logic [2:0] maskLvl_q;
  logic [NEST_W-1:0] nest_q;
  logic [31:0] rdMux;
  always_comb begin
    rdMux = '0;
    if (busAddr == REG_CTRL) begin
      rdMux[CTRL_STK16] = stk16_q;
      rdMux[CTRL_VEC16] = vec16_q;
      rdMux[CTRL_MASK_LSB +: 3] = maskLvl_q;
      rdMux[CTRL_NEST_LSB +: NEST_W] = nest_q;
    end else if (busAddr == REG_DMAVEC) begin
      rdMux = dmaVec_q;
    end else if (prioHit) begin
      rdMux = prio_q[prioSel*32 +: 32];
    end else if (busAddr == REG_PEND_LO) begin
      rdMux = pend_q[31:0];
    end else if (busAddr == REG_PEND_HI) begin
      rdMux[NUM_HW-33:0] = pend_q[NUM_HW-1:32];
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      waitReq_q <= 1'b1;
      rdata_q <= '0;
      dmaVec_q <= DMAVEC_RESET;
      prio_q <= '0;
      stk16_q <= 1'b0;
      vec16_q <= 1'b0;
    end else if (ce) begin
      waitReq_q <= ~busStart;
      if (busStart && avs_read) begin
        rdata_q <= rdMux;
      end
      if (wrCtrl) begin
        stk16_q <= avs_writedata[CTRL_STK16];
        vec16_q <= avs_writedata[CTRL_VEC16];
      end
      if (wrDma) begin
        dmaVec_q <= avs_writedata;
      end
      if (busStart && avs_write && prioHit) begin
        prio_q[prioSel*32 +: 32] <= avs_writedata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Priority resolution
  logic [2:0] bestLvl;
  logic [5:0] bestIdx;
  logic bestAny;
  logic [2:0] lvlJ;
  always_comb begin
    bestLvl = '0;
    bestIdx = '0;
    bestAny = 1'b0;
    lvlJ = '0;
    for (int j = 0; j < NUM_HW; j++) begin
      // Sources below NUM_NMI fixed at top level, masked only at mask level 7
      lvlJ = (j < NUM_NMI) ? LVL_TOP : prio_q[j*PRIO_FIELD_W +: 3];
      if (lvlJ == LVL_TOP && j >= NUM_NMI) begin
        lvlJ = 3'h6;
      end
      // Strictly greater keeps the smallest vector on ties
      if (pend_q[j] && lvlJ != 3'h0 && (!bestAny || lvlJ > bestLvl)) begin
        bestLvl = lvlJ;
        bestIdx = 6'(j + HW_BASE_IDX);
        bestAny = 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Mask updates and acceptance decision
  logic [2:0] maskNow;
  always_comb begin
    maskNow = maskLvl_q;
    if (maskAllInstr) begin
      maskNow = LVL_TOP;
    end else if (maskLoadInstr) begin
      maskNow = (maskLoadOperand == 3'h0) ? LVL_MIN_EI : maskLoadOperand;
    end else if (handlerReturnInstr) begin
      maskNow = restoredMaskLevel;
    end
  end
  pia_state_e state_q;
  logic [7:0] cnt_q;
  logic swPend_q;
  logic [7:0] swVec_q;
  wire atDecision = (state_q == PIA_IDLE && instrBoundary) || (state_q == PIA_DONE);
  wire takeSw = atDecision && swPend_q;
  wire takeHw = atDecision && !swPend_q && bestAny && (bestLvl > maskNow);
  wire [7:0] hwVec = vecOf(bestIdx);
  logic dmaHit;
  logic [1:0] dmaHitCh;
  always_comb begin
    dmaHit = 1'b0;
    dmaHitCh = '0;
    for (int c = NUM_DMA - 1; c >= 0; c--) begin
      if (dmaVec_q[c*8 +: 8] == {2'b00, bestIdx} && dmaVec_q[c*8 +: 8] != 8'h00 && !dmaCountZero[c]) begin
        dmaHit = 1'b1;
        dmaHitCh = 2'(c);
      end
    end
  end
  wire takeDma = takeHw && dmaHit;
  wire takeEntry = takeSw || (takeHw && !dmaHit);
  wire [7:0] entryLen = stk16_q ? (vec16_q ? ENTRY_1616 : ENTRY_168)
                                : (vec16_q ? ENTRY_816 : ENTRY_88);
  wire [5:0] bestSrc = 6'(bestIdx - 6'(HW_BASE_IDX));
  always_comb begin
    pendClr = '0;
    if (takeHw) begin
      pendClr[bestSrc] = 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Mask level and nesting count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      maskLvl_q <= LVL_MASK_RESET;
      nest_q <= '0;
    end else if (ce) begin
      if (takeHw && !dmaHit) begin
        maskLvl_q <= maskAfter(bestLvl);
      end else begin
        maskLvl_q <= maskNow;
      end
      if (takeEntry && !handlerReturnInstr) begin
        nest_q <= NEST_W'(nest_q + 1'b1);
      end else if (handlerReturnInstr && !takeEntry) begin
        nest_q <= NEST_W'(nest_q - 1'b1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Software trap latch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      swPend_q <= 1'b0;
      swVec_q <= '0;
    end else if (ce) begin
      if (illegalTrap) begin
        swPend_q <= 1'b1;
        swVec_q <= VEC_ILLEGAL;
      end else if (softwareTrapInstr) begin
        swPend_q <= 1'b1;
        swVec_q <= vecOf({3'h0, softwareTrapNum});
      end else if (takeSw) begin
        swPend_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Entry sequencer
  logic pushReq_q, handlerGo_q, dmaGo_q, entryBusy_q;
  logic [1:0] dmaCh_q;
  logic [23:0] vecAddr_q;
  logic [2:0] presLvl_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PIA_IDLE;
      cnt_q <= '0;
      pushReq_q <= 1'b0;
      handlerGo_q <= 1'b0;
      dmaGo_q <= 1'b0;
      dmaCh_q <= '0;
      vecAddr_q <= VEC_TABLE_BASE;
      presLvl_q <= '0;
      entryBusy_q <= 1'b0;
    end else if (ce) begin
      pushReq_q <= 1'b0;
      handlerGo_q <= 1'b0;
      dmaGo_q <= 1'b0;
      presLvl_q <= bestAny ? bestLvl : 3'h0;
      case (state_q)
        PIA_IDLE, PIA_DONE: begin
          if (takeEntry) begin
            state_q <= PIA_ENTRY;
            cnt_q <= 8'(entryLen - 8'h2);
            pushReq_q <= 1'b1;
            entryBusy_q <= 1'b1;
            vecAddr_q <= VEC_TABLE_BASE + {16'h0000, (takeSw ? swVec_q : hwVec)};
          end else if (state_q == PIA_DONE) begin
            state_q <= PIA_IDLE;
            handlerGo_q <= 1'b1;
            entryBusy_q <= 1'b0;
          end
          if (takeDma) begin
            dmaGo_q <= 1'b1;
            dmaCh_q <= dmaHitCh;
          end
        end
        PIA_ENTRY: begin
          if (cnt_q == 8'h00) begin
            state_q <= PIA_DONE;
          end else begin
            cnt_q <= 8'(cnt_q - 8'h1);
          end
        end
        default: begin
          state_q <= PIA_IDLE;
          entryBusy_q <= 1'b0;
        end
      endcase
    end
  end
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitReq_q;
  assign presentedLevel = presLvl_q;
  assign interruptMaskLevel = maskLvl_q;
  assign nestingCount = nest_q;
  assign entryBusy = entryBusy_q;
  assign pushReq = pushReq_q;
  assign vectorFetchAddr = vecAddr_q;
  assign handlerGo = handlerGo_q;
  assign dmaGo = dmaGo_q;
  assign dmaChannel = dmaCh_q;
  //////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] entCnt_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      entCnt_q <= '0;
    end else if (ce) begin
      entCnt_q <= pushReq_q ? 8'h1 : (entryBusy_q ? 8'(entCnt_q + 8'h1) : 8'h0);
    end
  end
  a_mask_after_reset: assert property (@(posedge core_clk)
    $rose(resetn) |-> maskLvl_q == LVL_MASK_RESET) else $error("mask not 7 after reset");
  a_accept_above_mask: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && atDecision && !swPend_q && bestAny && bestLvl <= maskNow) |=> !pushReq_q && !dmaGo_q)
    else $error("accepted at or below mask");
  a_mask_plus_one: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && takeHw && !dmaHit) |=> maskLvl_q == maskAfter($past(bestLvl))) else $error("mask not level plus one");
  a_sw_mask_kept: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && takeSw && !maskLoadInstr && !maskAllInstr && !handlerReturnInstr) |=> $stable(maskLvl_q))
    else $error("software trap changed mask");
  a_ei_zero_one: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && maskLoadInstr && maskLoadOperand == 3'h0 && !maskAllInstr && !takeHw) |=> maskLvl_q == LVL_MIN_EI)
    else $error("zero operand did not load one");
  a_di_sets_seven: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && maskAllInstr && !takeHw) |=> maskLvl_q == LVL_TOP) else $error("mask-all did not set 7");
  a_nest_increment: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && takeEntry && !handlerReturnInstr) |=> nest_q == NEST_W'($past(nest_q) + 1'b1))
    else $error("nesting count not incremented");
  a_vector_address: assert property (@(posedge core_clk) disable iff (!resetn)
    pushReq_q |-> vecAddr_q[23:8] == VEC_TABLE_BASE[23:8] && vecAddr_q[1:0] == 2'b00)
    else $error("vector address outside table");
  a_entry_length: assert property (@(posedge core_clk) disable iff (!resetn)
    (handlerGo_q && $past(ce)) |-> entCnt_q == entryLen) else $error("entry length wrong");
  a_pending_cleared: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && takeHw && !reqEdge[bestSrc]) |=> !pend_q[$past(bestSrc)]) else $error("pending not cleared");
  a_bus_one_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    (ce && busStart) |=> !avs_waitrequest) else $error("bus answer late");
  c_hw_entry: cover property (@(posedge core_clk) disable iff (!resetn) takeHw && !dmaHit);
  c_sw_entry: cover property (@(posedge core_clk) disable iff (!resetn) takeSw && maskLvl_q == LVL_TOP);
  c_nested: cover property (@(posedge core_clk) disable iff (!resetn) state_q == PIA_DONE && takeEntry);
  c_dma: cover property (@(posedge core_clk) disable iff (!resetn) takeDma);
endmodule : pia_intc
`default_nettype wire

// ==== verif/pia_seq_model.sv ====
// Purpose: Instruction sequencer model facing the interrupt block
// Assumes: One command at a time from the bench
// Notes: Operand lines toggle when no instruction qualifies them
`timescale 1ns/100ps
`default_nettype none
module pia_seq_model
  import pia_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic entryBusy,
  input wire logic slowMode,
  input wire logic cmdValid,
  input wire logic [2:0] cmdCode,
  input wire logic [2:0] cmdArg,
  output logic cmdDone,
  output logic instrBoundary,
  output logic softwareTrapInstr,
  output logic [2:0] softwareTrapNum,
  output logic illegalTrap,
  output logic maskLoadInstr,
  output logic [2:0] maskLoadOperand,
  output logic maskAllInstr,
  output logic handlerReturnInstr,
  output logic [2:0] restoredMaskLevel
);
  logic phase_q;
  logic [2:0] arg_q;
  logic fire;
  // Slow mode reaches a boundary every other cycle
  assign instrBoundary = !entryBusy && (!slowMode || phase_q);
  assign fire = cmdValid && !cmdDone && instrBoundary;
  assign softwareTrapNum = arg_q;
  assign maskLoadOperand = arg_q;
  assign restoredMaskLevel = arg_q;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 1'b0;
      arg_q <= 3'h0;
      cmdDone <= 1'b0;
      maskLoadInstr <= 1'b0;
      maskAllInstr <= 1'b0;
      softwareTrapInstr <= 1'b0;
      illegalTrap <= 1'b0;
      handlerReturnInstr <= 1'b0;
    end else begin
      phase_q <= !phase_q;
      cmdDone <= fire;
      arg_q <= fire ? cmdArg : ~arg_q;
      maskLoadInstr <= fire && cmdCode == 3'h1;
      maskAllInstr <= fire && cmdCode == 3'h2;
      softwareTrapInstr <= fire && cmdCode == 3'h3;
      illegalTrap <= fire && cmdCode == 3'h4;
      handlerReturnInstr <= fire && cmdCode == 3'h5;
    end
  end
endmodule : pia_seq_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the interrupt acceptance block
// Assumes: Sequencer model drives instructions on bench command
// Notes: Expected entries and reads are queued, a monitor compares
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pia_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [NUM_HW-1:0] hwReq = '0;
  logic [NUM_DMA-1:0] dmaCountZero = '0;
  logic slowMode = 1'b0;
  logic cmdValid = 1'b0;
  logic [2:0] cmdCode = 3'h0;
  logic [2:0] cmdArg = 3'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, cmdDone, iBnd, swTrap, illTrap, mLoad, mAll, hRet;
  logic [2:0] swNum, loadOp, restMask, presentedLevel, interruptMaskLevel;
  logic [7:0] nestingCount;
  logic entryBusy, pushReq, handlerGo, dmaGo;
  logic [1:0] dmaChannel;
  logic [23:0] vectorFetchAddr;
  logic [31:0] rdQ[$];
  logic [31:0] expQ[$];
  logic [31:0] seed = 32'h6710;
  int n_errors = 0;
  int cmp_count = 0;
  int expLen = 35;
  int cnt = 0;
  pia_intc #(.NEST_W(8)) pia_intc_i (.core_clk(core_clk), .resetn(resetn), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hwReq(hwReq), .instrBoundary(iBnd), .softwareTrapInstr(swTrap), .softwareTrapNum(swNum),
    .illegalTrap(illTrap), .maskLoadInstr(mLoad), .maskLoadOperand(loadOp), .maskAllInstr(mAll),
    .handlerReturnInstr(hRet), .restoredMaskLevel(restMask), .dmaCountZero(dmaCountZero),
    .presentedLevel(presentedLevel), .interruptMaskLevel(interruptMaskLevel),
    .nestingCount(nestingCount), .entryBusy(entryBusy), .pushReq(pushReq),
    .vectorFetchAddr(vectorFetchAddr), .handlerGo(handlerGo), .dmaGo(dmaGo), .dmaChannel(dmaChannel));
  pia_seq_model pia_seq_model_i (.core_clk(core_clk), .resetn(resetn), .entryBusy(entryBusy),
    .slowMode(slowMode), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdArg(cmdArg), .cmdDone(cmdDone),
    .instrBoundary(iBnd), .softwareTrapInstr(swTrap), .softwareTrapNum(swNum), .illegalTrap(illTrap),
    .maskLoadInstr(mLoad), .maskLoadOperand(loadOp), .maskAllInstr(mAll),
    .handlerReturnInstr(hRet), .restoredMaskLevel(restMask));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic hang();
    n_errors++;
    end_of_test();
  endtask : hang
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) hang();
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic doCmd(input logic [2:0] c, input logic [2:0] a);
    int i;
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdArg <= a;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (cmdDone === 1'b1) break;
    end
    if (i == 50) hang();
    cmdValid <= 1'b0;
    @(posedge core_clk);
  endtask : doCmd
  task automatic waitEv(input logic dma);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge core_clk);
      if ((dma ? dmaGo : handlerGo) === 1'b1) break;
    end
    if (i == 300) hang();
  endtask : waitEv
  task automatic ent(input logic [2:0] m, input logic [7:0] v);
    expQ.push_back({5'h0, m, VEC_TABLE_BASE + 24'(v)});
  endtask : ent
  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (resetn) begin
      cnt <= pushReq ? 1 : cnt + 1;
      if (handlerGo === 1'b1) check(cnt, expLen);
      if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, rdQ.size() ? rdQ.pop_front() : 32'hdead);
      if (pushReq === 1'b1 || dmaGo === 1'b1) check({4'h0, dmaGo, interruptMaskLevel,
        dmaGo ? {22'h0, dmaChannel} : vectorFetchAddr}, expQ.size() ? expQ.pop_front() : 32'hdead);
    end
  end
  initial begin
    #200000;
    hang();
  end
  initial begin
    logic [31:0] r;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(6'h00, 32'h00000700);
    r = xorshift();
    bus(1'b1, 6'h0f, r);
    rd(6'h0f, 32'h0);
    bus(1'b1, 6'h00, r);
    expLen = r[0] ? (r[1] ? 25 : 29) : (r[1] ? 31 : 35);
    rd(6'h00, {21'h0, 3'h7, 6'h0, r[1:0]});
    bus(1'b1, 6'h02, 32'h00743300);
    rd(6'h02, 32'h00743300);
    hwReq[3:2] <= 2'b11;
    repeat (8) @(posedge core_clk);
    check(presentedLevel, 32'h3);
    rd(6'h08, 32'h0000000c);
    ent(3'h4, 8'h28);
    ent(3'h7, 8'h20);
    doCmd(3'h1, 3'h0);
    hwReq[0] <= 1'b1;
    waitEv(1'b0);
    check(nestingCount, 32'h2);
    doCmd(3'h5, 3'h4);
    hwReq[4] <= 1'b1;
    repeat (8) @(posedge core_clk);
    check({nestingCount, interruptMaskLevel, presentedLevel}, {8'h1, 3'h4, 3'h4});
    hwReq <= '0;
    doCmd(3'h2, 3'h0);
    check(interruptMaskLevel, 32'h7);
    ent(3'h7, 8'h14);
    doCmd(3'h3, 3'h5);
    waitEv(1'b0);
    ent(3'h7, 8'h08);
    doCmd(3'h4, 3'h0);
    waitEv(1'b0);
    slowMode <= 1'b1;
    bus(1'b1, 6'h01, 32'h0000000c);
    doCmd(3'h5, 3'h7);
    doCmd(3'h5, 3'h7);
    expQ.push_back({5'h1, 3'h1, 22'h0, 2'h0});
    ent(3'h4, 8'h2c);
    doCmd(3'h5, 3'h1);
    waitEv(1'b0);
    dmaCountZero <= 4'h1;
    doCmd(3'h5, 3'h1);
    ent(3'h5, 8'h30);
    hwReq[4] <= 1'b1;
    waitEv(1'b0);
    rd(6'h00, {8'h0, 8'h1, 5'h0, 3'h5, 6'h0, r[1:0]});
    repeat (4) @(posedge core_clk);
    check(expQ.size() + rdQ.size(), 32'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
